// File: pwmj_map.svh
// Reset values, limits, codes and timing counts for the pulse width channel
`ifndef PWMJ_MAP_SVH
`define PWMJ_MAP_SVH

// System clock and time-base figures
`define PWMJ_CLK_HZ          10000000
`define PWMJ_TB_FINE_US      100
`define PWMJ_TB_COARSE_US    1000
`define PWMJ_TB_FINE_CYC     ((`PWMJ_CLK_HZ / 1000000) * `PWMJ_TB_FINE_US)
`define PWMJ_TB_COARSE_CYC   ((`PWMJ_CLK_HZ / 1000000) * `PWMJ_TB_COARSE_US)

// Output value scaling
`define PWMJ_PERMIL_FULL     16'd1000
`define PWMJ_ANALOG_FULL     16'd27648

// Parameter reset values, in time-base units
`define PWMJ_PERIOD_RST      16'd20000
`define PWMJ_DELAY_RST       16'd0
`define PWMJ_MINP_RST        16'd2

// Parameter limits, in time-base units
`define PWMJ_TIME_MAX        32'sd65535
`define PWMJ_PERIOD_MIN_FINE 32'sd4
`define PWMJ_PERIOD_MIN_CRS  32'sd1
`define PWMJ_MINP_MIN_FINE   32'sd2
`define PWMJ_MINP_MIN_CRS    32'sd0

// Channel number limits
`define PWMJ_CHAN_LIMIT      16'd3
`define PWMJ_CHAN_LAST       16'd2

// Job codes
`define PWMJ_JOB_NOP         16'h0000
`define PWMJ_JOB_WR_PERIOD   16'h0001
`define PWMJ_JOB_WR_DELAY    16'h0002
`define PWMJ_JOB_WR_MINP     16'h0004
`define PWMJ_JOB_RD_PERIOD   16'h0081
`define PWMJ_JOB_RD_DELAY    16'h0082
`define PWMJ_JOB_RD_MINP     16'h0084

// Job status codes
`define PWMJ_ST_OK           16'h0000
`define PWMJ_ST_PER_LOW      16'h0411
`define PWMJ_ST_PER_HIGH     16'h0412
`define PWMJ_ST_DLY_LOW      16'h0421
`define PWMJ_ST_DLY_HIGH     16'h0422
`define PWMJ_ST_MINP_LOW     16'h0431
`define PWMJ_ST_MINP_HIGH    16'h0432
`define PWMJ_ST_BAD_JOB      16'h04ff
`define PWMJ_ST_PARAM        16'h8001
`define PWMJ_ST_CHAN         16'h8009

`endif

// File: pwmj_pkg.sv
// Types shared by the pulse width channel modules
package pwmj_pkg;
    typedef logic [15:0] pwmj_time_t;
    typedef enum logic [1:0] {
        WV_IDLE  = 2'b00,
        WV_DELAY = 2'b01,
        WV_RUN   = 2'b10
    } pwmj_wave_st_t;
endpackage

// File: pwmj_wave_if.sv
// Parameter and status bundle between job logic and waveform engine
`timescale 1ns/1ps
interface pwmj_wave_if;
    import pwmj_pkg::*;
    logic       gate;
    logic       fmt_analog;
    logic       tb_coarse;
    pwmj_time_t period;
    pwmj_time_t delay;
    pwmj_time_t minp;
    pwmj_time_t duty;
    logic       out;
    logic       running;
    modport ctl  (output gate, fmt_analog, tb_coarse, period, delay, minp, duty, input out, running);
    modport wave (input gate, fmt_analog, tb_coarse, period, delay, minp, duty, output out, running);
endinterface

// File: pwmj_wave.sv
// Waveform engine: time-base divider, on-delay, period and pulse counters
`timescale 1ns/1ps
`include "pwmj_map.svh"
module pwmj_wave
    import pwmj_pkg::*;
#(
    parameter int TB_COARSE_CYC = `PWMJ_TB_COARSE_CYC
) (
    input  wire logic i_clk,   // System clock
    input  wire logic i_srst,  // Synchronous reset
    pwmj_wave_if.wave w        // Parameters in, pulse out
);
    logic [13:0]   div_q;
    logic [13:0]   div_lim;
    logic          tick;
    pwmj_wave_st_t st_q;
    pwmj_time_t    tcnt_q;
    pwmj_time_t    dly_q;
    pwmj_time_t    per_q;
    pwmj_time_t    width_q;
    logic          out_q;
    pwmj_time_t    width_new;

    // Pulse width for the period about to start, spikes removed
    function automatic pwmj_time_t calc_width(input pwmj_time_t duty, input pwmj_time_t per,
                                              input pwmj_time_t minp, input logic analog);
        logic [15:0] full;
        logic [15:0] dc;
        logic [31:0] prod;
        logic [15:0] wd;
        full = analog ? `PWMJ_ANALOG_FULL : `PWMJ_PERMIL_FULL;
        dc   = (duty > full) ? full : duty;
        prod = dc * per;
        wd   = 16'(prod / {16'h0000, full});
        if (wd < minp) begin
            wd = 16'h0000;
        end else if ((per - wd) < minp) begin
            wd = per;
        end
        return wd;
    endfunction

    assign width_new = calc_width(w.duty, w.period, w.minp, w.fmt_analog);

    // One-cycle tick per time-base unit; coarse count is a parameter so simulation can shorten it
    assign div_lim = w.tb_coarse ? 14'(TB_COARSE_CYC) : 14'(`PWMJ_TB_FINE_CYC);
    // Compare with >= so a switch to the shorter base never lets the divider run past its limit
    assign tick    = (div_q >= div_lim - 14'h0001);
    always_ff @(posedge i_clk) begin
        if (i_srst || tick || !w.gate) begin
            div_q <= 14'h0000;
        end else begin
            div_q <= div_q + 14'h0001;
        end
    end

    // Sequence: on-delay, then periods; delay is taken when the gate opens, period and width only at a period start
    always_ff @(posedge i_clk) begin
        if (i_srst || !w.gate) begin
            st_q    <= WV_IDLE;
            tcnt_q  <= 16'h0000;
            dly_q   <= 16'h0000;
            per_q   <= 16'h0001;
            width_q <= 16'h0000;
            out_q   <= 1'b0;
        end else begin
            unique case (st_q)
                WV_IDLE: begin
                    st_q   <= WV_DELAY;
                    tcnt_q <= 16'h0000;
                    dly_q  <= w.delay;
                end
                WV_DELAY: begin
                    if (tcnt_q == dly_q) begin
                        st_q    <= WV_RUN;
                        tcnt_q  <= 16'h0000;
                        per_q   <= w.period;
                        width_q <= width_new;
                        out_q   <= (width_new != 16'h0000);
                    end else if (tick) begin
                        tcnt_q <= tcnt_q + 16'h0001;
                    end
                end
                WV_RUN: begin
                    if (tick) begin
                        if (tcnt_q + 16'h0001 >= per_q) begin
                            tcnt_q  <= 16'h0000;
                            per_q   <= w.period;
                            width_q <= width_new;
                            out_q   <= (width_new != 16'h0000);
                        end else begin
                            tcnt_q <= tcnt_q + 16'h0001;
                            out_q  <= (tcnt_q + 16'h0001 < width_q);
                        end
                    end
                end
                default: begin
                    st_q  <= WV_IDLE;
                    out_q <= 1'b0;
                end
            endcase
        end
    end

    assign w.out     = out_q;
    assign w.running = (st_q == WV_RUN);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    // Output stays low while the on-delay runs
    delay_low_a: assert property (st_q == WV_DELAY |-> !out_q)
        else $error("pulse driven during on-delay");
    // Ticks are spaced by the divider count
    tick_space_a: assert property (tick |=> !tick [*8])
        else $error("time-base ticks too close");
    // Period end wraps the counter at the latched period
    period_wrap_a: assert property ((st_q == WV_RUN && w.gate && tick && tcnt_q + 16'h0001 >= per_q)
                                    |=> tcnt_q == 16'h0000)
        else $error("period counter did not wrap");
    pulse_high_c: cover property (st_q == WV_RUN && out_q ##1 !out_q);
endmodule

// File: pwmj_channel.sv
// Pulse width channel top: software gate, parameter job port, status outputs
`timescale 1ns/1ps
`include "pwmj_map.svh"
module pwmj_channel
    import pwmj_pkg::*;
#(
    parameter int TB_COARSE_CYC = `PWMJ_TB_COARSE_CYC
) (
    input  wire logic        i_clk,                // 10 MHz system clock
    input  wire logic        i_srst,               // Synchronous reset, active high
    input  wire logic        i_soft_gate_enable,   // Software gate request
    input  wire logic        i_fmt_analog,         // 1 selects analog scaling
    input  wire logic        i_timebase_1ms,       // 1 selects the 1 ms base
    input  wire logic [15:0] i_duty_value_in,      // Output value
    input  wire logic [15:0] i_channel,            // Channel number of the job
    input  wire logic        i_job_req,            // Job request, edge active
    input  wire logic [15:0] i_param_job_code,     // Job code
    input  wire logic [31:0] i_param_write_value,  // Value for write jobs
    input  wire logic        i_fault_pin,          // Driver overload sense pin
    output logic             o_pwm_out,            // Channel output
    output logic             o_gate_state_out,     // Internal gate state
    output logic             o_job_done,           // New job may start
    output logic             o_job_error,          // Last job failed
    output logic [15:0]      o_job_status,         // Last job status code
    output logic [31:0]      o_param_read_result,  // Read job result
    output logic             o_active_led,         // On while output is active
    output logic             o_fault_led,          // Overload indicator
    output logic             o_count_disable,      // Counter function blocked
    output logic             o_irq                 // Always low
);
    pwmj_wave_if wv ();

    logic        gate_q;
    logic        req_q;
    logic        pend_q;
    logic [15:0] code_q;
    logic [31:0] val_q;
    logic [15:0] chan_q;
    logic        done_q;
    logic        err_q;
    logic [15:0] stat_q;
    logic [31:0] rd_q;
    pwmj_time_t  period_q;
    pwmj_time_t  delay_q;
    pwmj_time_t  minp_q;
    logic        fault_s1_q;
    logic        fault_s2_q;
    logic        job_edge;
    logic [15:0] st_d;
    logic [31:0] rd_d;
    logic signed [31:0] val_s;
    logic signed [31:0] per_min;
    logic signed [31:0] minp_min;
    logic signed [31:0] minp_max;

    // Gate is registered so the status word and the engine see the same value
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            gate_q <= 1'b0;
        end else begin
            gate_q <= i_soft_gate_enable;
        end
    end

    // Fault pin comes from outside, so it passes two flops first
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            fault_s1_q <= 1'b0;
            fault_s2_q <= 1'b0;
        end else begin
            fault_s1_q <= i_fault_pin;
            fault_s2_q <= fault_s1_q;
        end
    end

    // Edges during a pending job are ignored; the controller should not issue them
    assign job_edge = i_job_req && !req_q && !pend_q;

    // Capture code and value on the edge, evaluate in the next cycle
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            req_q  <= 1'b0;
            pend_q <= 1'b0;
            code_q <= 16'h0000;
            val_q  <= 32'h0000_0000;
            chan_q <= 16'h0000;
        end else begin
            req_q  <= i_job_req;
            pend_q <= job_edge;
            if (job_edge) begin
                code_q <= i_param_job_code;
                val_q  <= i_param_write_value;
                chan_q <= i_channel;
            end
        end
    end

    // Lower limits of period and minimum pulse follow the selected time base; the minimum pulse ceiling is half the period
    assign val_s    = signed'(val_q);
    assign per_min  = i_timebase_1ms ? `PWMJ_PERIOD_MIN_CRS : `PWMJ_PERIOD_MIN_FINE;
    assign minp_min = i_timebase_1ms ? `PWMJ_MINP_MIN_CRS : `PWMJ_MINP_MIN_FINE;
    assign minp_max = signed'({17'h00000, period_q[15:1]});

    // Job decode and check; channel checks win over everything else
    always_comb begin
        st_d = `PWMJ_ST_OK;
        rd_d = rd_q;
        if (chan_q > `PWMJ_CHAN_LIMIT) begin
            st_d = `PWMJ_ST_CHAN;
        end else if (chan_q > `PWMJ_CHAN_LAST) begin
            st_d = `PWMJ_ST_PARAM;
        end else begin
            unique case (code_q)
                `PWMJ_JOB_NOP: st_d = `PWMJ_ST_OK;
                `PWMJ_JOB_WR_PERIOD: begin
                    if (val_s < per_min) st_d = `PWMJ_ST_PER_LOW;
                    else if (val_s > `PWMJ_TIME_MAX) st_d = `PWMJ_ST_PER_HIGH;
                end
                `PWMJ_JOB_WR_DELAY: begin
                    if (val_s < 32'sd0) st_d = `PWMJ_ST_DLY_LOW;
                    else if (val_s > `PWMJ_TIME_MAX) st_d = `PWMJ_ST_DLY_HIGH;
                end
                `PWMJ_JOB_WR_MINP: begin
                    if (val_s < minp_min) st_d = `PWMJ_ST_MINP_LOW;
                    else if (val_s > minp_max) st_d = `PWMJ_ST_MINP_HIGH;
                end
                `PWMJ_JOB_RD_PERIOD: rd_d = {16'h0000, period_q};
                `PWMJ_JOB_RD_DELAY:  rd_d = {16'h0000, delay_q};
                `PWMJ_JOB_RD_MINP:   rd_d = {16'h0000, minp_q};
                default: st_d = `PWMJ_ST_BAD_JOB;
            endcase
        end
    end

    // Job answer: done drops for the evaluation cycle, then returns with the result
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            done_q <= 1'b1;
            err_q  <= 1'b0;
            stat_q <= `PWMJ_ST_OK;
            rd_q   <= 32'h0000_0000;
        end else if (job_edge) begin
            done_q <= 1'b0;
        end else if (pend_q) begin
            done_q <= 1'b1;
            err_q  <= (st_d != `PWMJ_ST_OK);
            stat_q <= st_d;
            if (st_d == `PWMJ_ST_OK) begin
                rd_q <= rd_d;
            end
        end
    end

    // Parameters change only on a clean write; the engine samples delay when the gate opens, period and minimum pulse at period start
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            period_q <= `PWMJ_PERIOD_RST;
            delay_q  <= `PWMJ_DELAY_RST;
            minp_q   <= `PWMJ_MINP_RST;
        end else if (pend_q && st_d == `PWMJ_ST_OK) begin
            if (code_q == `PWMJ_JOB_WR_PERIOD) period_q <= val_q[15:0];
            if (code_q == `PWMJ_JOB_WR_DELAY)  delay_q  <= val_q[15:0];
            if (code_q == `PWMJ_JOB_WR_MINP)   minp_q   <= val_q[15:0];
        end
    end

    // Engine inputs
    assign wv.gate       = gate_q;
    assign wv.fmt_analog = i_fmt_analog;
    assign wv.tb_coarse  = i_timebase_1ms;
    assign wv.period     = period_q;
    assign wv.delay      = delay_q;
    assign wv.minp       = minp_q;
    assign wv.duty       = i_duty_value_in;

    pwmj_wave #(
        .TB_COARSE_CYC (TB_COARSE_CYC)
    ) u_wave (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .w      (wv)
    );

    // Outputs; the status indicator is the output itself, so it cannot disagree
    assign o_pwm_out           = wv.out;
    assign o_active_led        = wv.out;
    assign o_fault_led         = fault_s2_q;
    assign o_gate_state_out    = gate_q;
    assign o_count_disable     = gate_q;
    assign o_irq               = 1'b0;
    assign o_job_done          = done_q;
    assign o_job_error         = err_q;
    assign o_job_status        = stat_q;
    assign o_param_read_result = rd_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    done_pulse_a: assert property (job_edge |=> !o_job_done ##1 o_job_done)
        else $error("job done did not drop for one cycle");
    err_status_a: assert property (o_job_error |-> o_job_status != 16'h0000)
        else $error("job error without status code");
    fail_keep_a: assert property ((pend_q && st_d != 16'h0000)
                                  |=> $stable(period_q) && $stable(delay_q) && $stable(minp_q))
        else $error("failed job changed a parameter");
    write_apply_a: assert property ((pend_q && st_d == 16'h0000 && code_q == 16'h0001)
                                    |=> period_q == $past(val_q[15:0]))
        else $error("period write not applied");
    read_result_a: assert property ((pend_q && st_d == 16'h0000 && code_q == 16'h0082)
                                    |=> o_param_read_result == {16'h0000, $past(delay_q)})
        else $error("read result wrong");
    bad_job_a: assert property ((pend_q && chan_q <= 16'h0002 && code_q == 16'h0003)
                                |=> o_job_status == 16'h04ff && o_job_error)
        else $error("invalid job not reported");
    chan_err_a: assert property ((pend_q && chan_q > 16'h0003) |=> o_job_status == 16'h8009)
        else $error("channel error not reported");
    gate_low_a: assert property (!gate_q |=> !o_pwm_out)
        else $error("output high with gate closed");
    no_irq_a: assert property (!o_irq)
        else $error("interrupt raised");
    wr_ok_c: cover property (pend_q && st_d == 16'h0000 && code_q == 16'h0001);
    rd_ok_c: cover property (pend_q && st_d == 16'h0000 && code_q == 16'h0081);
    err_c:   cover property (o_job_error && o_job_done);
endmodule

// File: pwmj_actuator.sv
// Actuator model on the channel output: pulse timing and overload sense
`timescale 1ns/1ps
module pwmj_actuator (
    input  wire logic        i_clk,      // System clock
    input  wire logic        i_pwm,      // Drive from the channel
    input  wire logic        i_short,    // Bench shorts the load
    output logic             o_fault,    // Overload sense to the channel
    output logic [15:0]      o_high_len, // Cycles of the last pulse
    output logic [15:0]      o_rises     // Pulses seen so far
);
    logic        prev_q;
    logic [15:0] run_q;
    // A shorted load reports at once; the channel passes it through its own two-flop synchroniser
    assign o_fault = i_short;
    // Known start so the counters never carry unknowns
    initial begin
        prev_q     = 1'b0;
        run_q      = 16'h0;
        o_high_len = 16'h0;
        o_rises    = 16'h0;
    end
    // Length is taken after the fall, so a pulse in flight never shows
    always @(posedge i_clk) begin
        prev_q <= i_pwm;
        if (i_pwm && !prev_q) begin
            o_rises <= o_rises + 16'h1;
            run_q   <= 16'h1;
        end else if (i_pwm) begin
            run_q <= run_q + 16'h1;
        end else if (prev_q) begin
            o_high_len <= run_q;
        end
    end
endmodule

// File: pwmj_channel_bench.sv
// Self-checking bench for the pulse width channel and its job port
`timescale 1ns/1ps
module pwmj_channel_bench;
    localparam int TB = 20; // Short coarse base keeps the run brief
    // Table rows: channel, job code, write value, expected status
    localparam logic [79:0] CASES [17] = '{
        80'h0000_0001_0000ffff_0000, 80'h0000_0002_0000ffff_0000, 80'h0000_0004_00000000_0000,
        80'h0000_0001_00000001_0000, 80'h0000_0001_00000000_0411, 80'h0000_0001_00010000_0412,
        80'h0000_0002_ffffffff_0421, 80'h0000_0002_00010000_0422, 80'h0000_0004_ffffffff_0431,
        80'h0000_0001_00000008_0000, 80'h0000_0004_00000005_0432, 80'h0000_0004_00000004_0000,
        80'h0000_0003_00000000_04ff, 80'h0004_0001_00000014_8009, 80'h0003_0001_00000014_8001,
        80'h0000_0002_00000003_0000, 80'h0000_0000_00000000_0000};
    logic        clk, srst, gate, fmt, tb1ms, req, short_cmd;
    logic        pwm, gst, done, err, act, fled, cdis, irq, fpin;
    logic [15:0] duty, chan, code, st, hlen, rises, keep;
    logic [31:0] wval, rres;
    int          fail_count, comparisons, per, k, n;

    pwmj_channel #(.TB_COARSE_CYC(TB)) u_pwmj_channel (
        .i_clk(clk), .i_srst(srst), .i_soft_gate_enable(gate), .i_fmt_analog(fmt),
        .i_timebase_1ms(tb1ms), .i_duty_value_in(duty), .i_channel(chan), .i_job_req(req),
        .i_param_job_code(code), .i_param_write_value(wval), .i_fault_pin(fpin),
        .o_pwm_out(pwm), .o_gate_state_out(gst), .o_job_done(done), .o_job_error(err),
        .o_job_status(st), .o_param_read_result(rres), .o_active_led(act), .o_fault_led(fled),
        .o_count_disable(cdis), .o_irq(irq));
    pwmj_actuator u_pwmj_actuator (
        .i_clk(clk), .i_pwm(pwm), .i_short(short_cmd), .o_fault(fpin), .o_high_len(hlen), .o_rises(rises));

    // Free-running 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Request is dropped first, so every job gets its own rising edge
    task automatic job(input logic [15:0] ch, input logic [15:0] c, input logic [31:0] v);
        int m;
        @(posedge clk) req <= 1'b0;
        @(posedge clk);
        chan <= ch;
        code <= c;
        wval <= v;
        req  <= 1'b1;
        m = 0;
        do begin
            @(negedge clk);
            m++;
        end while (done !== 1'b0 && m < 8);
        chk("done low", 32'h0, 32'(done));
        m = 0;
        do begin
            @(negedge clk);
            m++;
        end while (done !== 1'b1 && m < 8);
        chk("done high", 32'h1, 32'(done));
    endtask

    task automatic jchk(input logic [15:0] ch, input logic [15:0] c, input logic [31:0] v, input logic [15:0] es);
        job(ch, c, v);
        chk("job status", 32'(es), 32'(st));
        chk("job error", 32'(es != 16'h0), 32'(err));
    endtask

    task automatic rd(input logic [15:0] c, input logic [31:0] e);
        jchk(16'h0, c, 32'h0, 16'h0);
        chk("read result", e, rres);
    endtask

    // Pulse width in base units, with short pulses and pauses filtered
    function automatic int exp_w(int d, int full, int p, int mp);
        int w;
        w = d * p / full;
        if (w < mp) w = 0;
        if (p - w < mp) w = p;
        return w;
    endfunction

    // Wait for a whole pulse, then one cycle more for the model to latch it
    task automatic wait_fall();
        int m;
        m = 0;
        do begin
            @(negedge clk);
            m++;
        end while (pwm !== 1'b1 && m < 4000);
        m = 0;
        do begin
            @(negedge clk);
            m++;
        end while (pwm !== 1'b0 && m < 4000);
        @(negedge clk);
        chk("pulse fall", 32'h1, 32'(m < 4000));
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard, well beyond the few thousand cycles the tests need
    initial begin
        #(20000 * 100);
        fail_count++;
        $display("[ERR] watchdog expected finish seen timeout");
        tally_and_finish();
    end

    initial begin
        {srst, gate, fmt, tb1ms, req, short_cmd} = 6'b100000;
        {duty, chan, code, wval} = 80'h0;
        void'($urandom(70));
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk("done", 32'h1, 32'(done));
        chk("status", 32'h0, 32'({err, st}));
        chk("irq", 32'h0, 32'(irq));
        rd(16'h81, 32'd20000);
        rd(16'h82, 32'd0);
        rd(16'h84, 32'd2);
        jchk(16'h0, 16'h1, 32'd3, 16'h0411);
        jchk(16'h0, 16'h1, 32'd4, 16'h0);
        jchk(16'h0, 16'h4, 32'd1, 16'h0431);
        jchk(16'h0, 16'h4, 32'd2, 16'h0);
        $display("test reset and fine limits done");
        @(posedge clk) tb1ms <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            per = 1 + $urandom % 65535;
            k = $urandom % 65536;
            n = $urandom % (per / 2 + 1);
            jchk(16'h0, 16'h1, 32'(per), 16'h0);
            jchk(16'h0, 16'h2, 32'(k), 16'h0);
            jchk(16'h0, 16'h4, 32'(n), 16'h0);
            rd(16'h81, 32'(per));
            rd(16'h82, 32'(k));
            rd(16'h84, 32'(n));
        end
        for (int i = 0; i < 17; i++) begin
            jchk(CASES[i][79:64], CASES[i][63:48], CASES[i][47:16], CASES[i][15:0]);
        end
        rd(16'h81, 32'd8);
        rd(16'h82, 32'd3);
        rd(16'h84, 32'd4);
        jchk(16'h0, 16'h3, 32'h0, 16'h04ff);
        @(posedge clk);
        code <= 16'h1;
        repeat (6) @(negedge clk);
        chk("held request", 32'h104ff, {15'h0, done, st});
        jchk(16'h0, 16'h4, 32'h0, 16'h0);
        $display("test job port done");
        @(posedge clk);
        duty <= 16'd500;
        gate <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pwm !== 1'b1 && n < 400);
        chk("delay floor", 32'h1, 32'(n >= 3 * TB));
        chk("delay ceiling", 32'h1, 32'(n <= 5 * TB));
        chk("gate and block", 32'h7, {29'h0, gst, cdis, act});
        for (int i = 0; i < 6; i++) begin
            k = 1 + $urandom % 7;
            @(posedge clk);
            fmt  <= 1'(i % 2);
            duty <= (i % 2) ? 16'(k * 3456) : 16'(k * 125);
            wait_fall();
            wait_fall();
            per = (i % 2) ? exp_w(k * 3456, 27648, 8, 0) : exp_w(k * 125, 1000, 8, 0);
            chk("pulse length", 32'(per * TB), 32'(hlen));
        end
        $display("test output scaling done");
        jchk(16'h0, 16'h4, 32'd2, 16'h0);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            fmt  <= 1'b0;
            duty <= i ? 16'd875 : 16'd125;
            repeat (200) @(negedge clk);
            keep = rises;
            repeat (400) @(negedge clk);
            chk("no spikes", 32'(keep), 32'(rises));
            chk("level", 32'(i * 3), {30'h0, pwm, act});
        end
        @(posedge clk) duty <= 16'd500;
        // Output was held high; end that stretch so the next rise is a true period start
        wait_fall();
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pwm !== 1'b1 && n < 400);
        chk("period start", 32'h1, 32'(pwm));
        jchk(16'h0, 16'h1, 32'd16, 16'h0);
        wait_fall();
        chk("old period", 32'(4 * TB), 32'(hlen));
        wait_fall();
        chk("new period", 32'(8 * TB), 32'(hlen));
        $display("test filter and update done");
        @(posedge clk) gate <= 1'b0;
        repeat (3) @(negedge clk);
        chk("gate closed", 32'h0, {29'h0, pwm, gst, cdis});
        keep = rises;
        repeat (300) @(negedge clk);
        chk("quiet", 32'(keep), 32'(rises));
        @(posedge clk) short_cmd <= 1'b1;
        repeat (4) @(negedge clk);
        chk("fault on", 32'h1, 32'(fled));
        @(posedge clk) short_cmd <= 1'b0;
        repeat (4) @(negedge clk);
        chk("fault off", 32'h0, {30'h0, fled, irq});
        $display("test gate and indicators done");
        tally_and_finish();
    end
endmodule
